// File: logic/xpt_pkg.sv
// constants shared by the crosspoint switch and its bench
// assumes a single 100 MHz clock and an AXI4-Lite register port
package xpt_pkg;
    // register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_OUT = 4'h8;
    localparam logic [3:0] ADDR_COUNT = 4'hc;
    // control fields
    localparam int CTRL_HOLD = 0;      // keep unaddressed outputs
    localparam int CTRL_OUTREG = 1;    // 1 registered, 0 direct
    localparam int CTRL_MODE_LSB = 2;  // two-bit input mode
    localparam int CTRL_FALL = 4;      // capture on falling edge
    localparam int CTRL_CLKSEL = 5;    // 0 strobe a, 1 strobe b
    localparam logic [7:0] CTRL_RESET = 8'h03;
    // input modes
    localparam logic [1:0] MODE_FLOW = 2'h0;
    localparam logic [1:0] MODE_LATCH = 2'h1;
    localparam logic [1:0] MODE_EDGE = 2'h2;
    // status fields
    localparam int ST_FULL = 0;
    localparam int ST_EMPTY = 1;
    localparam int ST_STABLE = 2;
    localparam int ST_LEVEL_LSB = 4;
    // one buffer entry: {dest[2:0], source[2:0], data[7:0]}
    localparam int NUM_PORTS = 8;
    localparam int SEL_W = 3;
    localparam int ENTRY_W = NUM_PORTS + 2 * SEL_W;
    localparam int SRC_LSB = NUM_PORTS;
    localparam int DST_LSB = NUM_PORTS + SEL_W;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 17;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// File: logic/crosspoint_switch_eight_by_eight.sv
// eight-in, eight-out single-bit crosspoint switch with axi4-lite control
// assumes pins are synchronous to aclk; strobe inputs are sampled levels
//
// How it works
// - three source bits pick one data input
// - three destination bits pick output, binary index
// - one shared selected bit gated per output
// - hold keeps unaddressed outputs at last value
// - hold is own value and-not decode, or-ed
// - outputs registered or driven straight through
// - inputs flow-through or captured on strobe edges
// - optional transparent latch on input pins
// - flow-through inputs must settle 17 ns first in MODE_FLOW; mode 3 passes pins unsettled
// - selected bit reaches output within one cycle
`timescale 1ns/1ps
module crosspoint_switch_eight_by_eight #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [7:0] switch_data_in,
    input wire logic source_select_bit0,
    input wire logic source_select_bit1,
    input wire logic source_select_bit2,
    input wire logic dest_select_bit0,
    input wire logic dest_select_bit1,
    input wire logic dest_select_bit2,
    input wire logic cap_strobe_a,
    input wire logic cap_strobe_b,
    input wire logic latch_open,
    input wire logic route_valid,
    output logic route_ready,
    output logic apply_valid,
    input wire logic apply_ready,
    output logic [7:0] switch_out
);
    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);
    localparam int EW = xpt_pkg::ENTRY_W;
    localparam int SW = xpt_pkg::SEL_W;

    // overview of the data path, front to back:
    // pins are packed into one word of data, source index and destination index
    // the input mode picks that word live, from the latch, or from the edge capture
    // a small buffer sits between the pin side and the output side
    // so a stalled receiver never loses a route that was already offered
    // the head of the buffer drives one shared selected bit
    // every output gates that bit with its own destination decode
    // the hold term keeps unaddressed outputs, or clears them when hold is off
    // limitation: with hold on, only one output changes per applied route
    // limitation: the capture strobes are sampled levels, not real clocks,
    // so a strobe pulse shorter than one aclk period can be missed
    // trade-off: sampling the strobes keeps the whole block on one clock

    // whole module state in one record
    typedef struct packed {
        logic [7:0] ctrl;                 // control register
        logic strobe_a;                   // last sample of strobe a
        logic strobe_b;                   // last sample of strobe b
        logic [EW-1:0] capt;              // edge-captured inputs
        logic [EW-1:0] latch;             // latch contents while closed
        logic [EW-1:0] prev;              // last pin sample, for settling
        logic [1:0] stab;                 // cycles the pins held still
        logic [BUF_DEPTH-1:0][EW-1:0] mem; // route buffer
        logic [PTR_W-1:0] wp;
        logic [PTR_W-1:0] rp;
        logic [CNT_W-1:0] cnt;
        logic [7:0] outs;                 // registered outputs
        logic [15:0] routed;              // applied routes
        logic awv;                        // write address held
        logic [3:0] aw;
        logic wv;                         // write data held
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [EW-1:0] pins;         // raw pin word
    logic [EW-1:0] front;        // word after input mode
    logic [1:0] mode;
    logic strobe_now;            // chosen strobe level
    logic strobe_was;
    logic cap_edge;              // selected edge seen
    logic stable;                // pins settled long enough
    logic full;
    logic empty;
    logic push;
    logic pop;
    logic [EW-1:0] head;         // oldest buffered route
    logic [SW-1:0] src;
    logic [SW-1:0] dst;
    logic selected_data_term;    // shared input multiplexer
    logic [7:0] dest_hit;        // one-hot destination decode
    logic [7:0] next_out;        // value each output takes on apply
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic [31:0] rmux;
    logic [1:0] rsel;

    // pin word packing
    assign pins = {dest_select_bit2, dest_select_bit1, dest_select_bit0,
                   source_select_bit2, source_select_bit1, source_select_bit0,
                   switch_data_in};
    assign mode = s_q.ctrl[xpt_pkg::CTRL_MODE_LSB +: 2];

    // strobe edge detect on the chosen capture strobe
    assign strobe_now = s_q.ctrl[xpt_pkg::CTRL_CLKSEL] ? cap_strobe_b : cap_strobe_a;
    assign strobe_was = s_q.ctrl[xpt_pkg::CTRL_CLKSEL] ? s_q.strobe_b : s_q.strobe_a;
    assign cap_edge = s_q.ctrl[xpt_pkg::CTRL_FALL] ? (strobe_was & ~strobe_now)
                                                   : (~strobe_was & strobe_now);

    // input word by mode
    always_comb begin
        case (mode)
            xpt_pkg::MODE_LATCH: front = latch_open ? pins : s_q.latch;
            xpt_pkg::MODE_EDGE: front = s_q.capt;
            default: front = pins; // flow-through
        endcase
    end

    // MODE_FLOW words are only taken once the pins have settled; mode 3 also passes the pins but skips this check
    // the live compare against the last sample closes the gap of the cycle
    // in which the pins change but the settle count has not yet dropped;
    // without it a word could be taken on the very cycle the pins move
    assign stable = (s_q.stab >= 2'(xpt_pkg::SETTLE_CYC)) & (pins == s_q.prev);

    // buffer flags and handshakes
    assign full = (s_q.cnt == CNT_W'(BUF_DEPTH));
    assign empty = (s_q.cnt == '0);
    assign route_ready = ~full & ((mode != xpt_pkg::MODE_FLOW) | stable);
    assign apply_valid = ~empty;
    assign push = route_valid & route_ready;
    assign pop = apply_valid & apply_ready;
    assign head = s_q.mem[s_q.rp];

    // shared selection, built once for all outputs
    assign src = head[xpt_pkg::SRC_LSB +: SW];
    assign dst = head[xpt_pkg::DST_LSB +: SW];
    assign selected_data_term = head[src];

    // per-output gate and hold term
    for (genvar i = 0; i < 8; i++) begin : g_out
        assign dest_hit[i] = (dst == SW'(i));
        assign next_out[i] = (selected_data_term & dest_hit[i])
                           | (s_q.ctrl[xpt_pkg::CTRL_HOLD] & ~dest_hit[i]
                              & s_q.outs[i]);
    end

    // output pins: registered copy, or the live next value while a route waits
    // direct mode shows the value the head route would give, so the
    // selected bit reaches the pin in the same cycle it is offered
    // with an empty buffer there is nothing to show but the registered copy
    // hazard: in direct mode the pins may glitch as the head changes
    always_comb begin
        if (s_q.ctrl[xpt_pkg::CTRL_OUTREG] | empty) begin
            switch_out = s_q.outs;
        end else begin
            switch_out = next_out; // direct path, same cycle
        end
    end

    // bus handshakes; one write and one read at a time
    // each write half is held in its own slot until both are present
    // the response is raised the cycle after both halves are held
    // no new half is taken while a response waits, which keeps the
    // slots from being overwritten before the write commits
    // reads answer one cycle after the address is taken
    // the read slot stays busy until the master takes the data
    assign awready = ~s_q.awv & ~s_q.bv;
    assign wready = ~s_q.wv & ~s_q.bv;
    assign arready = ~s_q.rv;
    assign aw_take = awvalid & awready;
    assign w_take = wvalid & wready;
    assign ar_take = arvalid & arready;
    assign bvalid = s_q.bv;
    assign bresp = s_q.br;
    assign rvalid = s_q.rv;
    assign rdata = s_q.rd;
    assign rresp = s_q.rr;

    // read data select
    always_comb begin
        rmux = 32'h0;
        rsel = xpt_pkg::RESP_OKAY;
        case (araddr)
            xpt_pkg::ADDR_CTRL: rmux[7:0] = s_q.ctrl;
            xpt_pkg::ADDR_STATUS: begin
                rmux[xpt_pkg::ST_FULL] = full;
                rmux[xpt_pkg::ST_EMPTY] = empty;
                rmux[xpt_pkg::ST_STABLE] = stable;
                rmux[xpt_pkg::ST_LEVEL_LSB +: CNT_W] = s_q.cnt;
            end
            xpt_pkg::ADDR_OUT: rmux[7:0] = switch_out;
            xpt_pkg::ADDR_COUNT: rmux[15:0] = s_q.routed;
            default: rsel = xpt_pkg::RESP_DECERR; // unmapped
        endcase
    end

    // next state
    // every register of the block is written here, in one place, so the
    // order of the updates below decides which wins when two collide
    // reset comes last on purpose: it overrides everything above
    // the buffer pointers wrap at the depth, which need not be a power of two
    // the level counter moves only when exactly one side acts
    // the settle counter saturates, so it never wraps back to unsettled
    // the route counter wraps silently at its width
    always_comb begin
        s_d = s_q;
        // strobe history
        s_d.strobe_a = cap_strobe_a;
        s_d.strobe_b = cap_strobe_b;
        // edge capture
        if (cap_edge) begin
            s_d.capt = pins;
        end
        // transparent latch follows while open
        if (latch_open) begin
            s_d.latch = pins;
        end
        // settle counter, saturating
        s_d.prev = pins;
        if (pins != s_q.prev) begin
            s_d.stab = 2'h0;
        end else if (!stable) begin
            s_d.stab = s_q.stab + 2'h1;
        end
        // buffer write side
        if (push) begin
            s_d.mem[s_q.wp] = front;
            s_d.wp = (s_q.wp == PTR_W'(BUF_DEPTH - 1)) ? '0 : s_q.wp + PTR_W'(1);
        end
        // buffer read side applies one route per cycle
        if (pop) begin
            s_d.rp = (s_q.rp == PTR_W'(BUF_DEPTH - 1)) ? '0 : s_q.rp + PTR_W'(1);
            s_d.outs = next_out; // rising edge update
            s_d.routed = s_q.routed + 16'h1;
        end
        // level tracks both sides
        if (push & ~pop) begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
        end else if (pop & ~push) begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
        end
        // write address and data, either order
        if (aw_take) begin
            s_d.awv = 1'b1;
            s_d.aw = awaddr;
        end
        if (w_take) begin
            s_d.wv = 1'b1;
            s_d.wd = wdata;
            s_d.ws = wstrb;
        end
        // commit once both halves are held
        if (s_q.awv & s_q.wv & ~s_q.bv) begin
            s_d.awv = 1'b0;
            s_d.wv = 1'b0;
            s_d.bv = 1'b1;
            s_d.br = xpt_pkg::RESP_OKAY;
            case (s_q.aw)
                xpt_pkg::ADDR_CTRL: begin
                    if (s_q.ws[0]) begin
                        s_d.ctrl = s_q.wd[7:0];
                    end
                end
                xpt_pkg::ADDR_STATUS, xpt_pkg::ADDR_OUT, xpt_pkg::ADDR_COUNT: begin
                    s_d.br = xpt_pkg::RESP_OKAY; // read-only, write ignored
                end
                default: s_d.br = xpt_pkg::RESP_DECERR;
            endcase
        end
        if (s_q.bv & bready) begin
            s_d.bv = 1'b0;
        end
        // read answer registered on the same edge that takes the address
        if (ar_take) begin
            s_d.rv = 1'b1;
            s_d.rd = rmux;
            s_d.rr = rsel;
        end else if (s_q.rv & rready) begin
            s_d.rv = 1'b0;
        end
        // synchronous reset, outputs cleared so holds start defined
        if (!aresetn) begin
            s_d = '0;
            s_d.ctrl = xpt_pkg::CTRL_RESET;
        end
    end

    // the only flip-flops
    // all state moves together on the rising edge; no other process
    // holds memory, which keeps the reset and the timing in one spot
    always_ff @(posedge aclk) begin
        s_q <= s_d;
    end
endmodule

// File: verif/xpt_sva.sv
// port-level assertions for the crosspoint switch
// assumes one clock aclk and synchronous active-low aresetn
`timescale 1ns/1ps
module xpt_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic route_valid,
    input wire logic route_ready,
    input wire logic apply_valid,
    input wire logic apply_ready,
    input wire logic [7:0] switch_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write halves taken at one edge
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    // read address taken
    sequence s_rd_take;
        arvalid && arready;
    endsequence
    // route pushed into the buffer; some buffer word must be offered the cycle after the push
    sequence s_push;
        route_valid && route_ready;
    endsequence
    a_write_answer: assert property (s_wr_take |-> ##2 bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_rd_take |=> rvalid)
        else $error("read data missing");
    a_bvalid_stands: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped early");
    a_rvalid_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped or changed");
    a_read_block: assert property (rvalid |-> !arready)
        else $error("second read accepted");
    a_push_apply: assert property (s_push |=> apply_valid)
        else $error("pushed route not offered");
    a_stall_keeps: assert property (apply_valid && !apply_ready |=> apply_valid)
        else $error("stalled route lost");
    a_out_steady: assert property (!apply_valid ##1 !apply_valid |-> $stable(switch_out))
        else $error("outputs moved without a route");
    // reset must clear outputs, so this one is never disabled
    a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> switch_out == 8'h00)
        else $error("outputs not cleared by reset");
endmodule
bind crosspoint_switch_eight_by_eight xpt_sva i_sva (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
    .route_valid, .route_ready, .apply_valid, .apply_ready, .switch_out);

// File: verif/apply_sink.sv
// receiver at the far side of the route buffer
// assumes the bench drives stall at clock edges
`timescale 1ns/1ps
module apply_sink (
    input wire logic stall,
    output logic apply_ready
);
    // takes every route unless told to stall, so the buffer can fill
    assign apply_ready = !stall;
endmodule

// File: verif/tb.sv
// self-checking bench for the crosspoint switch
// assumes the design package and the checker are compiled first
`timescale 1ns/1ps
module tb;
    logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0, rdata, r;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, route_ready, apply_valid, apply_ready;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] switch_data_in = 8'h00, switch_out, e, v;
    logic source_select_bit0 = 1'b0, source_select_bit1 = 1'b0, source_select_bit2 = 1'b0;
    logic dest_select_bit0 = 1'b0, dest_select_bit1 = 1'b0, dest_select_bit2 = 1'b0;
    logic cap_strobe_a = 1'b0, cap_strobe_b = 1'b0, latch_open = 1'b0, route_valid = 1'b0;
    int fails = 0, check_count = 0, cycles = 0;
    crosspoint_switch_eight_by_eight i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .switch_data_in, .source_select_bit0,
        .source_select_bit1, .source_select_bit2, .dest_select_bit0, .dest_select_bit1,
        .dest_select_bit2, .cap_strobe_a, .cap_strobe_b, .latch_open, .route_valid,
        .route_ready, .apply_valid, .apply_ready, .switch_out);
    apply_sink i_sink (.stall, .apply_ready);
    // 100 MHz clock
    initial begin
        forever #5 aclk = ~aclk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, far above the expected run length
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // axi write: both halves offered together, each dropped when taken
    // handshakes are sampled mid-cycle, before the edge that takes them
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        logic hit;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        do begin
            @(negedge aclk);
            aw_done = aw_done | awready;
            w_done = w_done | wready;
            @(posedge aclk);
            if (aw_done) awvalid <= 1'b0;
            if (w_done) wvalid <= 1'b0;
        end while (!(aw_done && w_done));
        do begin
            @(negedge aclk);
            hit = bvalid;
            resp = bresp;
            @(posedge aclk);
        end while (!hit);
        bready <= 1'b0;
    endtask
    // axi read: result lands in r and resp
    task automatic rd(input logic [3:0] a);
        logic hit;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            hit = arready;
            @(posedge aclk);
        end while (!hit);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            hit = rvalid;
            r = rdata;
            resp = rresp;
            @(posedge aclk);
        end while (!hit);
        rready <= 1'b0;
    endtask
    task automatic pins(input logic [2:0] s, input logic [2:0] d, input logic [7:0] x);
        switch_data_in <= x;
        {source_select_bit2, source_select_bit1, source_select_bit0} <= s;
        {dest_select_bit2, dest_select_bit1, dest_select_bit0} <= d;
    endtask
    // pins stay put until the push, so settle time is always met
    task automatic route(input logic [2:0] s, input logic [2:0] d, input logic [7:0] x);
        logic took;
        @(posedge aclk);
        pins(s, d, x);
        route_valid <= 1'b1;
        do begin
            @(negedge aclk);
            took = route_ready;
            @(posedge aclk);
        end while (!took);
        route_valid <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge aclk);
        #1;
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(xpt_pkg::ADDR_CTRL);
        chk(r, 32'(xpt_pkg::CTRL_RESET));
        chk(32'(switch_out), 32'h0);
        rd(4'h2);
        chk(32'(resp), 32'(xpt_pkg::RESP_DECERR));
        $display("test reset done");
        e = 8'h00;
        for (int i = 0; i < 8; i++) begin
            v = 8'ha5 ^ (8'h01 << i);
            e[7 - i] = v[i];
            route(3'(i), 3'(7 - i), v);
            settle();
            chk(32'(switch_out), 32'(e));
        end
        rd(xpt_pkg::ADDR_COUNT);
        chk(r, 32'h8);
        $display("test routing done");
        wr(xpt_pkg::ADDR_CTRL, 32'h0);
        chk(32'(resp), 32'(xpt_pkg::RESP_OKAY));
        stall <= 1'b1;
        route(3'h3, 3'h5, 8'h08);
        settle();
        chk(32'(switch_out), 32'h20);
        route(3'h0, 3'h1, 8'h01);
        settle();
        chk(32'(route_ready), 32'h0);
        rd(xpt_pkg::ADDR_STATUS);
        chk(r & 32'h3, 32'h1);
        stall <= 1'b0;
        settle();
        chk(32'(switch_out), 32'h02);
        $display("test buffer done");
        e = 8'h02;
        for (int k = 0; k < 4; k++) begin
            wr(xpt_pkg::ADDR_CTRL, 32'h0b | 32'(k << 4));
            cap_strobe_a <= k[0];
            cap_strobe_b <= k[0];
            pins(3'h2, 3'(k), 8'h04);
            repeat (4) @(posedge aclk);
            if (k[1]) cap_strobe_b <= ~k[0];
            else cap_strobe_a <= ~k[0];
            repeat (4) @(posedge aclk);
            route(3'h2, 3'(k), 8'h00);
            e[k] = 1'b1;
            settle();
            chk(32'(switch_out), 32'(e));
        end
        $display("test capture done");
        wr(xpt_pkg::ADDR_CTRL, 32'h07);
        latch_open <= 1'b1;
        pins(3'h5, 3'h6, 8'h20);
        repeat (2) @(posedge aclk);
        latch_open <= 1'b0;
        route(3'h5, 3'h6, 8'h00);
        e[6] = 1'b1;
        settle();
        chk(32'(switch_out), 32'(e));
        $display("test latch done");
        close_out();
    end
endmodule
